/* hw/dmrc_pkg.sv */
/*
  Shared constants and types for the debug mode and reset control block.
  Assumes a 32-bit register port and a single 125 MHz clock.
*/
package dmrc_pkg;

  localparam int DMRC_ADDR_W = 8;
  localparam int DMRC_DATA_W = 32;

  // register offsets on the plain register port
  localparam logic [7:0] OFS_DSCR = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // communication channel access mode encodings
  localparam logic [1:0] ACC_NONBLOCK = 2'h0;
  localparam logic [1:0] ACC_STALL = 2'h1;
  localparam logic [1:0] ACC_FAST = 2'h2;

  // entry cause codes kept in the control register
  localparam logic [3:0] ENTRY_NONE = 4'h0;
  localparam logic [3:0] ENTRY_BKPT = 4'h1;
  localparam logic [3:0] ENTRY_WPT = 4'h3;

  localparam logic [31:0] DSCR_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] SYNC_RESET = 4'h0;

  // debug status and control register layout, msb first
  typedef struct packed {
    logic [9:0] rsvd_hi;     // 31:22
    logic [1:0] access_mode; // 21:20
    logic [3:0] rsvd_mid;    // 19:16
    logic monitor_en;        // 15
    logic halt_en;           // 14
    logic [6:0] rsvd_lo;     // 13:7
    logic cancelled;         // 6
    logic [3:0] entry;       // 5:2
    logic rsvd1;             // 1
    logic halted;            // 0
  } dmrc_dscr_t;

  // read-only status word
  typedef struct packed {
    logic [26:0] rsvd;
    logic sv_busy;
    logic standby;
    logic dbg_en;
    logic sys_rst;
    logic dbg_rst;
  } dmrc_status_t;

  // breakpoint and watchpoint match strobes from the core
  typedef struct packed {
    logic bkpt;
    logic wpt;
  } dmrc_match_t;

  // answer to a debugger system-view access
  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } dmrc_sv_resp_t;

  typedef enum {SV_IDLE, SV_WAIT} dmrc_sv_state_t;

endpackage

/* hw/dmrc_debug_ctrl.sv */
/*
  Debug mode and reset control: the debug status and control register,
  gating of breakpoint and watchpoint events, the debug reset and the
  answer to debugger system-view accesses cut by a system reset.
  Assumes pins arrive asynchronously, core match strobes and fabric
  completion are on clock_i, and the register master never waits.
*/
`timescale 1ns/1ns
module dmrc_debug_ctrl
  import dmrc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [DMRC_ADDR_W-1:0] reg_addr_i,
  input wire logic [DMRC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DMRC_DATA_W-1:0] reg_rdata_o,
  input wire logic debug_reset_n_i,
  input wire logic system_reset_n_i,
  input wire logic standby_wait_indication_i,
  input wire logic invasive_debug_enable_i,
  input wire dmrc_match_t match_i,
  input wire logic restart_i,
  output logic halt_req_o,
  output logic monitor_exc_o,
  output logic event_cancel_o,
  output logic core_halted_o,
  output logic [1:0] comm_channel_access_mode_o,
  input wire logic sv_req_i,
  input wire logic sys_done_i,
  input wire logic sys_err_i,
  input wire logic [DMRC_DATA_W-1:0] sys_rdata_i,
  output dmrc_sv_resp_t sv_resp_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic dbg_rst;
  logic sys_in_reset;
  logic dbg_en;
  logic standby;

  // two stages per pin; only the second stage is read below
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_meta <= SYNC_RESET;
      pin_sync <= SYNC_RESET;
    end else if (ce_i) begin
      pin_meta <= {standby_wait_indication_i, invasive_debug_enable_i,
                   system_reset_n_i, debug_reset_n_i};
      pin_sync <= pin_meta;
    end
  end

  // resets read as asserted until the pins have been sampled
  assign dbg_rst = ~pin_sync[0];
  assign sys_in_reset = ~pin_sync[1];
  assign dbg_en = pin_sync[2];
  assign standby = pin_sync[3];

  ////////////////////////////////////////////////////////////////////////////
  // debug status and control register

  dmrc_dscr_t dscr;
  dmrc_dscr_t wr_val;
  logic dscr_wr;
  logic dscr_zero_wr;
  logic pend_valid;
  logic [3:0] pend_entry;
  logic next_halt;
  logic next_mon;
  logic next_cancel;

  assign wr_val = dmrc_dscr_t'(reg_wdata_i);
  assign dscr_wr = reg_wr_i && reg_hit(reg_addr_i, OFS_DSCR);
  assign dscr_zero_wr = dscr_wr && (reg_wdata_i == ZERO_WORD);

  // the debug clock keeps running in standby, so the reset is not lost
  always_ff @(posedge clock_i) begin
    if (rst_i || dbg_rst) begin
      dscr <= DSCR_RESET;
    end else if (ce_i) begin
      if (dscr_zero_wr) begin
        dscr <= DSCR_RESET;
      end else if (dscr_wr) begin
        dscr.halt_en <= wr_val.halt_en;
        dscr.monitor_en <= wr_val.monitor_en;
        dscr.access_mode <= wr_val.access_mode;
      end
      if (restart_i) begin
        dscr.halted <= 1'b0;
      end
      // hardware events come last so a set beats a same-cycle clear
      if (next_halt) begin
        dscr.halted <= 1'b1;
        dscr.entry <= pend_entry;
      end
      if (next_cancel) begin
        dscr.cancelled <= 1'b1;
      end
    end
  end

  assign core_halted_o = dscr.halted;
  assign comm_channel_access_mode_o = dscr.access_mode;

  ////////////////////////////////////////////////////////////////////////////
  // debug event gating

  logic events_allowed;

  // no event is even captured without the invasive enable
  assign events_allowed = dbg_en && (dscr.halt_en || dscr.monitor_en) && !dscr.halted;

  always_ff @(posedge clock_i) begin
    if (rst_i || dbg_rst) begin
      pend_valid <= 1'b0;
      pend_entry <= ENTRY_NONE;
    end else if (ce_i) begin
      pend_valid <= events_allowed && (match_i.bkpt || match_i.wpt);
      pend_entry <= match_i.bkpt ? ENTRY_BKPT : ENTRY_WPT;
    end
  end

  // enables are looked at again at delivery; a match whose mode vanished
  // is cancelled so the core completes the access instead of waiting
  always_comb begin
    next_halt = pend_valid && dbg_en && dscr.halt_en;
    next_mon = pend_valid && dbg_en && !dscr.halt_en && dscr.monitor_en;
    next_cancel = pend_valid && !(next_halt || next_mon);
  end

  // event strobes, one cycle each
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      halt_req_o <= 1'b0;
      monitor_exc_o <= 1'b0;
      event_cancel_o <= 1'b0;
    end else if (ce_i) begin
      halt_req_o <= next_halt;
      monitor_exc_o <= next_mon;
      event_cancel_o <= next_cancel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system-view access answer

  dmrc_sv_state_t sv_state;

  // requests made while a previous one is open are ignored
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sv_state <= SV_IDLE;
    end else if (ce_i) begin
      case (sv_state)
        SV_IDLE: begin
          if (sv_req_i && !sys_in_reset) begin
            sv_state <= SV_WAIT;
          end
        end
        SV_WAIT: begin
          if (sys_in_reset || sys_done_i) begin
            sv_state <= SV_IDLE;
          end
        end
        default: begin
          sv_state <= SV_IDLE;
        end
      endcase
    end
  end

  // a reset beats a completion in the same cycle: the data are suspect
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sv_resp_o <= '0;
    end else if (ce_i) begin
      sv_resp_o <= '0;
      if (sv_state == SV_IDLE && sv_req_i && sys_in_reset) begin
        sv_resp_o.valid <= 1'b1;
        sv_resp_o.err <= 1'b1;
      end else if (sv_state == SV_WAIT && sys_in_reset) begin
        sv_resp_o.valid <= 1'b1;
        sv_resp_o.err <= 1'b1;
      end else if (sv_state == SV_WAIT && sys_done_i) begin
        sv_resp_o.valid <= 1'b1;
        sv_resp_o.err <= sys_err_i;
        sv_resp_o.rdata <= sys_err_i ? ZERO_WORD : sys_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read path

  dmrc_status_t status;

  always_comb begin
    status = '0;
    status.sv_busy = (sv_state == SV_WAIT);
    status.standby = standby;
    status.dbg_en = dbg_en;
    status.sys_rst = sys_in_reset;
    status.dbg_rst = dbg_rst;
  end

  // unmapped offsets read zero; data stand one cycle only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= ZERO_WORD;
    end else if (ce_i) begin
      if (reg_rd_i && reg_hit(reg_addr_i, OFS_DSCR)) begin
        reg_rdata_o <= dscr;
      end else if (reg_rd_i && reg_hit(reg_addr_i, OFS_STATUS)) begin
        reg_rdata_o <= status;
      end else begin
        reg_rdata_o <= ZERO_WORD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_SV_RESET_ERR: assert property (
    ce_i && sv_state == SV_WAIT && sys_in_reset |=> sv_resp_o.valid && sv_resp_o.err)
    else $error("system-view access cut by reset not answered with error");

  AST_MODE_WRITE: assert property (
    ce_i && dscr_wr && !dscr_zero_wr && !dbg_rst
    |=> dscr.halt_en == $past(wr_val.halt_en) && dscr.monitor_en == $past(wr_val.monitor_en))
    else $error("mode enable bits did not take the written value");

  AST_EVENT_NEEDS_EN: assert property (
    halt_req_o || monitor_exc_o |-> $past(dbg_en) && $past(pend_valid))
    else $error("debug event raised without invasive debug enable");

  AST_EVENT_RESOLVES: assert property (
    ce_i && pend_valid && !dbg_rst |=> $onehot({halt_req_o, monitor_exc_o, event_cancel_o}))
    else $error("pending match neither delivered nor cancelled");

  AST_DBG_RESET: assert property (
    dbg_rst ##1 !dbg_rst |-> dscr == DSCR_RESET)
    else $error("debug reset left control register dirty");

  AST_RESET_IN_STANDBY: assert property (
    dbg_rst && standby |=> dscr == DSCR_RESET && comm_channel_access_mode_o == ACC_NONBLOCK)
    else $error("debug reset ignored in standby");

  AST_ZERO_WRITE: assert property (
    ce_i && dscr_zero_wr && !next_halt && !next_cancel |=> dscr == DSCR_RESET)
    else $error("zero write did not restore reset values");

  AST_HALT_PRIORITY: assert property (
    ce_i && pend_valid && dbg_en && dscr.halt_en && dscr.monitor_en && !dbg_rst
    |=> halt_req_o && !monitor_exc_o && core_halted_o)
    else $error("halt mode did not win over monitor mode");

  // halted may already be set by the previous match, so only the strobes are checked
  AST_CANCEL_WHEN_OFF: assert property (
    ce_i && pend_valid && !dscr.halt_en && !dscr.monitor_en && !dbg_rst
    |=> event_cancel_o && !halt_req_o && !monitor_exc_o)
    else $error("event delivered with both modes off");

  AST_SV_REQ_IN_RESET: assert property (
    ce_i && sv_state == SV_IDLE && sv_req_i && sys_in_reset |=> sv_resp_o.valid && sv_resp_o.err)
    else $error("system-view request during reset not answered with error");

  AST_NO_EVENT_WITHOUT_EN: assert property (
    ce_i && !dbg_en |=> !halt_req_o && !monitor_exc_o)
    else $error("debug event raised while invasive debug enable low");

  AST_MONITOR_ONLY: assert property (
    ce_i && pend_valid && dbg_en && !dscr.halt_en && dscr.monitor_en && !dbg_rst
    |=> monitor_exc_o && !halt_req_o)
    else $error("monitor mode alone did not raise a monitor exception");

  COV_SV_RESET: cover property (sv_state == SV_WAIT && sys_in_reset ##1 sv_resp_o.err);
  COV_HALT: cover property (pend_valid ##1 halt_req_o);
  COV_MONITOR: cover property (pend_valid ##1 monitor_exc_o);
  COV_CANCEL: cover property (pend_valid ##1 event_cancel_o);
  COV_STANDBY_RST: cover property (standby && dbg_rst ##1 !dbg_rst);

endmodule

/* bench/dmrc_fabric_model.sv */
/*
  System fabric model: answers a debugger system-view access.
  Assumes one open access at a time, all on clock_i.
*/
`timescale 1ns/1ns
module dmrc_fabric_model (
  input wire logic clock_i,
  input wire logic sv_req_i,
  input wire logic hold_i,
  input wire logic [31:0] data_i,
  output logic done_o,
  output logic [31:0] rdata_o
);
  int cnt = 0;
  initial done_o = 1'b0;
  initial rdata_o = 32'h0;
  ////////////////////////////////////////////////////////////////////
  // answer three cycles after the request; hold_i drops the access
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    rdata_o <= ~rdata_o; // released data lines never keep a value
    if (sv_req_i) begin
      cnt <= 3;
    end else if (hold_i) begin
      cnt <= 0; // bench is resetting the system, never answer
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
      rdata_o <= data_i;
    end
  end
endmodule

/* bench/testbench.sv */
/*
  Self-checking bench for the debug mode and reset control block.
  Assumes the fabric model beside it and a 125 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
  import dmrc_pkg::*;
  logic clock_i = 0, rst_i = 1, wr = 0, rd = 0, rd_d = 0;
  logic dbg_n = 1, sys_n = 1, stby = 0, en = 1, restart = 0;
  logic sv_req = 0, hold = 0, done;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdata, sv_data = 0, fdata, r;
  logic [31:0] seed = 32'h4bb56910;
  logic [1:0] mode;
  logic halt, mon, canc, hltd;
  dmrc_match_t match = '0;
  dmrc_sv_resp_t resp;
  logic [33:0] rq[$], eq[$], sq[$];
  int err_total = 0, compares = 0;
  always #4 clock_i = ~clock_i;
  dmrc_debug_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .debug_reset_n_i(dbg_n), .system_reset_n_i(sys_n),
    .standby_wait_indication_i(stby), .invasive_debug_enable_i(en),
    .match_i(match), .restart_i(restart), .halt_req_o(halt),
    .monitor_exc_o(mon), .event_cancel_o(canc), .core_halted_o(hltd),
    .comm_channel_access_mode_o(mode), .sv_req_i(sv_req), .sys_done_i(done),
    .sys_err_i(1'b0), .sys_rdata_i(fdata), .sv_resp_o(resp));
  dmrc_fabric_model u_fab (.clock_i(clock_i), .sv_req_i(sv_req),
    .hold_i(hold), .data_i(sv_data), .done_o(done), .rdata_o(fdata));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one-cycle strobes with an idle cycle after, so no double drive
  task wr32(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd32(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back({2'b00, exp});
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(posedge clock_i);
  endtask
  task fire(input dmrc_match_t m, input logic [2:0] e);
    if (e != 3'b000) eq.push_back({31'h0, e});
    match <= m;
    @(posedge clock_i);
    match <= '0;
    repeat (3) @(posedge clock_i);
  endtask
  task go(input logic [7:0] n);
    restart <= 1'b1;
    @(posedge clock_i);
    restart <= 1'b0;
    @(posedge clock_i);
    check({33'h0, hltd}, 34'h0);
    $display("test %0d done", n);
  endtask
  ////////////////////////////////////////////////////////////////////
  // watcher: each result takes the oldest note of its kind
  always @(posedge clock_i) rd_d <= rd;
  always @(negedge clock_i) begin
    if (rd_d) check({2'b00, rdata}, rq.pop_front());
    if (halt | mon | canc) check({31'h0, halt, mon, canc}, eq.pop_front());
    if (resp.valid) check({1'b0, resp.err, resp.rdata}, sq.pop_front());
  end
  initial begin
    repeat (3000) @(posedge clock_i);
    err_total++;
    $display("wrong value at %0t: run hung", $time);
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rd32(OFS_DSCR, DSCR_RESET);
    rd32(OFS_STATUS, 32'h4);
    rd32(8'h08, ZERO_WORD);
    for (int m = 0; m < 4; m++) begin
      wr32(OFS_DSCR, {10'h0, m[1:0], 20'h0});
      check({32'h0, mode}, {32'h0, m[1:0]});
    end
    go(1);
    // halt only, monitor only, both: halt wins
    wr32(OFS_DSCR, 32'h0000_4000);
    fire(2'b10, 3'b100);
    check({33'h0, hltd}, 34'h1);
    rd32(OFS_DSCR, 32'h0000_4005);
    go(2);
    wr32(OFS_DSCR, 32'h0000_8000);
    fire(2'b01, 3'b010);
    go(3);
    wr32(OFS_DSCR, 32'h0000_c000);
    fire(2'b11, 3'b100);
    rd32(OFS_DSCR, 32'h0000_c005);
    go(4);
    // enable low: no event even with both modes on
    en <= 1'b0;
    repeat (4) @(posedge clock_i);
    fire(2'b11, 3'b000);
    en <= 1'b1;
    repeat (4) @(posedge clock_i);
    // zero write lands on the edge that takes the match, so delivery finds modes off
    wr32(OFS_DSCR, 32'h0000_8000);
    eq.push_back({31'h0, 3'b001});
    match <= 2'b10;
    wr <= 1'b1;
    wdata <= ZERO_WORD;
    @(posedge clock_i);
    match <= '0;
    wr <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd32(OFS_DSCR, 32'h0000_0040);
    wr32(OFS_DSCR, ZERO_WORD);
    rd32(OFS_DSCR, DSCR_RESET);
    go(5);
    // debug reset pulse while in standby
    wr32(OFS_DSCR, 32'h0020_c000);
    stby <= 1'b1;
    dbg_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    dbg_n <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd32(OFS_DSCR, DSCR_RESET);
    check({32'h0, mode}, {32'h0, ACC_NONBLOCK});
    wr32(OFS_DSCR, ZERO_WORD);
    stby <= 1'b0;
    go(6);
    // plain accesses, then one cut by a system reset
    repeat (2) begin
      r = rnd();
      sv_data <= r;
      sq.push_back({2'b00, r});
      sv_req <= 1'b1;
      @(posedge clock_i);
      sv_req <= 1'b0;
      repeat (8) @(posedge clock_i);
    end
    hold <= 1'b1;
    sq.push_back({2'b01, 32'h0});
    sv_req <= 1'b1;
    @(posedge clock_i);
    sv_req <= 1'b0;
    sys_n <= 1'b0;
    repeat (6) @(posedge clock_i);
    sys_n <= 1'b1;
    hold <= 1'b0;
    repeat (4) @(posedge clock_i);
    go(7);
    check(34'(rq.size() + eq.size() + sq.size()), 34'h0);
    stop_test();
  end
endmodule
